// ==== common/snvc_pkg.sv ====
// snvc_pkg: constants and types of the spi nonvolatile sram core
// assumes: shared by the core and its bench; no clocking of its own
package snvc_pkg;
  localparam int MEM_DEPTH = 32768;
  localparam int ADDR_W = 15;
  // opcodes
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDIS = 8'h04;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_ASOFF = 8'h19;
  localparam logic [7:0] OP_SAVE = 8'h3C;
  localparam logic [7:0] OP_ASON = 8'h59;
  localparam logic [7:0] OP_RESTORE = 8'h60;
  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_PIN_EN = 7;
  // guarded regions start here; TOP_ADDR is the last address
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 15'h6000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 15'h4000;
  localparam logic [ADDR_W-1:0] TOP_ADDR = 15'h7FFF;
  // reset values
  localparam logic AUTO_SAVE_RST = 1'b1;
  localparam logic [1:0] GUARD_RST = 2'h0;
  // phase counter loads in MCLK cycles; each phase lasts one cycle more
  localparam logic [15:0] ERASE_CYC = 16'h0040;
  localparam logic [15:0] PROG_CYC = 16'h0040;
  localparam logic [15:0] RCL_CLR_CYC = 16'h0010;
  localparam logic [15:0] RCL_LOAD_CYC = 16'h0020;

  typedef enum logic [2:0] {SP_OPC, SP_ADDR, SP_DUMMY, SP_WR, SP_RD, SP_SRD, SP_SWR,
    SP_IGN} snvc_spi_st_t;
  typedef enum logic [2:0] {NV_IDLE, NV_ERASE, NV_PROG, NV_RCL_CLR,
    NV_RCL_LOAD} snvc_nv_st_t;
  typedef struct packed {
    logic wr;
    logic save;
    logic rcl;
    logic as_off;
    logic as_on;
  } snvc_ev_t;
  typedef struct packed {
    logic erasing;
    logic programming;
    logic restoring;
  } snvc_phase_t;
endpackage

// ==== sim/snvc_spi_master.sv ====
// snvc_spi_master: spi bus master model in mode 0 or 3, msb first
// assumes: the bench calls frame; sck half period 16 ns, still between frames
`timescale 1ns/10ps
module snvc_spi_master (
  // spi link
  output logic SCK,
  output logic CS_N,
  output logic SI,
  output logic HOLD_N,
  input wire logic SO
);
  // idle clock level: 0 gives mode 0, 1 gives mode 3; set by the bench between frames
  bit cpol;
  initial begin
    cpol = 1'b0;
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
    HOLD_N = 1'b1;
  end
  // sends tx, then clocks nrd bytes in; a pause of four clocks before bit hb
  task automatic frame(input logic [7:0] tx[$], input int nrd, input int hb,
      output logic [7:0] rx[$]);
    logic [7:0] b;
    int n;
    rx = {};
    b = 8'h00;
    n = (tx.size() + nrd) * 8;
    SCK = cpol;
    #16 CS_N = 1'b0;
    // mode 3 needs a fall before the first rise; no edge in mode 0
    #16 SCK = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == hb) begin
        // pause only after the fall, so the bit already on SO stays valid
        #4 HOLD_N = 1'b0;
        // clocks during the pause carry junk that must be ignored
        repeat (4) begin
          SI = ~SI;
          #16 SCK = 1'b1;
          #16 SCK = 1'b0;
        end
        #4 HOLD_N = 1'b1;
      end
      SI = (i < tx.size() * 8) ? tx[i / 8][7 - i % 8] : ~SI;
      #16 SCK = 1'b1;
      b = {b[6:0], SO};
      #16 SCK = (i == n - 1) ? cpol : 1'b0;
      if (i % 8 == 7 && i >= tx.size() * 8) rx.push_back(b);
    end
    #16 CS_N = 1'b1;
    SI = ~SI;
    #32;
  endtask
endmodule // snvc_spi_master

// ==== sim/spi_nv_sram_store_control_test.sv ====
// spi_nv_sram_store_control_test: self-checking bench of snvc_core
// assumes: snvc_spi_master drives the link; a byte model predicts all reads
`timescale 1ns/10ps
module spi_nv_sram_store_control_test
  import snvc_pkg::*;
  ;
  localparam int ERS_LEN = int'(ERASE_CYC) + 1;
  localparam int SAVE_LEN = ERS_LEN + int'(PROG_CYC) + 1;
  localparam int RCL_LEN = int'(RCL_CLR_CYC) + int'(RCL_LOAD_CYC) + 2;
  logic MCLK, RST_N, WP_N, POWER_FAIL, req_pull, AUTO_SAVE_EN;
  wire SCK, CS_N, SI, HOLD_N, SO, SO_OE;
  wire SAVE_BUSY_REQUEST_PIN_OUT, SAVE_BUSY_REQUEST_PIN_OE, SAVE_BUSY_REQUEST_PIN_IN;
  snvc_phase_t NV_PHASE;
  int err_count, comparisons, wel, guard, pin_en;
  int gb[4] = '{0, 32'h6000, 32'h4000, 32'h8000};
  logic [7:0] mem [int];
  logic [7:0] rx[$];
  // open-drain wire with pull-up: low when either party pulls
  assign SAVE_BUSY_REQUEST_PIN_IN = !(SAVE_BUSY_REQUEST_PIN_OE || req_pull);
  snvc_core i_snvc_core (.MCLK(MCLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI),
    .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE), .WP_N(WP_N), .POWER_FAIL(POWER_FAIL),
    .SAVE_BUSY_REQUEST_PIN_IN(SAVE_BUSY_REQUEST_PIN_IN),
    .SAVE_BUSY_REQUEST_PIN_OUT(SAVE_BUSY_REQUEST_PIN_OUT),
    .SAVE_BUSY_REQUEST_PIN_OE(SAVE_BUSY_REQUEST_PIN_OE), .NV_PHASE(NV_PHASE),
    .AUTO_SAVE_EN(AUTO_SAVE_EN));
  snvc_spi_master i_snvc_spi_master (.SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N),
    .SO(SO));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  function automatic bit prot(int a);
    return !wel || (pin_en && !WP_N) || guard == 3 || (guard == 1 && a >= QUARTER_BASE)
      || (guard == 2 && a >= HALF_BASE);
  endfunction
  task automatic cmd(input logic [7:0] op);
    i_snvc_spi_master.frame({op}, 0, -1, rx);
  endtask
  task automatic stat;
    i_snvc_spi_master.frame({OP_RDSTAT}, 1, -1, rx);
    check(rx[0], {pin_en[0], 3'h0, guard[1:0], wel[0], 1'b0});
  endtask
  task automatic wst(input logic [7:0] v);
    i_snvc_spi_master.frame({OP_WRSTAT, v}, 0, -1, rx);
    pin_en = v[7];
    guard = v[3:2];
    stat();
  endtask
  task automatic wr(input int a, input int n);
    logic [7:0] tx[$];
    logic [7:0] d;
    tx = {OP_WRITE, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      tx.push_back(d);
      if (!prot((a + i) % MEM_DEPTH)) mem[(a + i) % MEM_DEPTH] = d;
    end
    i_snvc_spi_master.frame(tx, 0, -1, rx);
  endtask
  task automatic rd(input int a, input int n, input bit fast, input int hb, input bit busy);
    logic [7:0] tx[$];
    tx = {fast ? OP_FREAD : OP_READ, a[15:8], a[7:0]};
    if (fast) tx.push_back(8'h00);
    i_snvc_spi_master.frame(tx, n, hb, rx);
    for (int i = 0; i < n; i++) check(rx[i], busy ? 8'hFF : mem[(a + i) % MEM_DEPTH]);
    check(SO_OE, 0);
  endtask
  task automatic busy_len(input int et, input int ee);
    int t = 0;
    int e = 0;
    int p = 0;
    int w = 0;
    do begin
      @(negedge MCLK);
      if (++w > 60) begin
        err_count++;
        end_of_test();
      end
    end while (SAVE_BUSY_REQUEST_PIN_OE !== 1'b1);
    check(SAVE_BUSY_REQUEST_PIN_OUT, 0);
    while (SAVE_BUSY_REQUEST_PIN_OE === 1'b1 && t < 1000) begin
      t++;
      e += NV_PHASE.erasing;
      p += NV_PHASE.programming;
      @(negedge MCLK);
    end
    check(t, et);
    check(e, ee);
    check(p, (ee > 0) ? int'(PROG_CYC) + 1 : 0);
  endtask
  task automatic no_busy(input int n);
    repeat (n) begin
      @(negedge MCLK);
      check(SAVE_BUSY_REQUEST_PIN_OE, 0);
    end
  endtask
  // waits first so a just-written dirty flag has crossed over
  task automatic pull;
    repeat (4) @(negedge MCLK);
    req_pull = 1'b1;
    repeat (3) @(negedge MCLK);
    req_pull = 1'b0;
  endtask
  initial begin
    RST_N = 1'b0;
    WP_N = 1'b1;
    POWER_FAIL = 1'b0;
    req_pull = 1'b0;
    err_count = 0;
    comparisons = 0;
    wel = 0;
    guard = 0;
    pin_en = 0;
    void'($urandom(32'h5a86e562));
    repeat (16) @(negedge MCLK);
    check(SAVE_BUSY_REQUEST_PIN_OE, 1);
    check(NV_PHASE.restoring, 1);
    check(AUTO_SAVE_EN, AUTO_SAVE_RST);
    RST_N = 1'b1;
    repeat (60) if (SAVE_BUSY_REQUEST_PIN_OE === 1'b1) @(negedge MCLK);
    check(SAVE_BUSY_REQUEST_PIN_OE, 0);
    cmd(OP_WRDIS);
    stat();
    done("reset");
    cmd(OP_WREN);
    wel = 1;
    stat();
    wr(32'hFFFE, 3);
    rd(32'h7FFE, 3, 0, -1, 0);
    i_snvc_spi_master.cpol = 1'b1;
    rd(32'h7FFF, 2, 1, 36, 0);
    for (int i = 0; i < 3; i++) wr(gb[i + 1] - 1, 2);
    i_snvc_spi_master.cpol = 1'b0;
    done("burst");
    for (int g = 1; g < 4; g++) begin
      wst(8'(g << 2));
      wr(gb[g] - 1, 2);
      rd(gb[g] - 1, 2, 0, -1, 0);
    end
    wst(8'h00);
    done("guard");
    fork
      begin
        cmd(OP_SAVE);
        rd(32'h4000, 1, 0, -1, 1);
      end
      busy_len(SAVE_LEN, ERS_LEN);
    join
    fork
      cmd(OP_SAVE);
      busy_len(SAVE_LEN, ERS_LEN);
    join
    done("save");
    fork
      pull();
      no_busy(20);
    join
    wst(8'h80);
    @(negedge MCLK);
    WP_N = 1'b0;
    wr(32'h4000, 1);
    fork
      pull();
      no_busy(20);
    join
    @(negedge MCLK);
    WP_N = 1'b1;
    wr(32'h4000, 1);
    fork
      pull();
      busy_len(SAVE_LEN, ERS_LEN);
    join
    rd(32'h4000, 1, 0, -1, 0);
    wst(8'h00);
    cmd(OP_WRDIS);
    wel = 0;
    wr(32'h5FFF, 1);
    rd(32'h5FFF, 1, 0, -1, 0);
    stat();
    cmd(OP_WREN);
    wel = 1;
    done("protect");
    cmd(OP_ASOFF);
    repeat (4) @(negedge MCLK);
    check(AUTO_SAVE_EN, 0);
    wr(32'h3FFF, 1);
    repeat (4) @(negedge MCLK);
    POWER_FAIL = 1'b1;
    rd(32'h3FFF, 1, 0, -1, 1);
    no_busy(5);
    POWER_FAIL = 1'b0;
    cmd(OP_ASON);
    repeat (4) @(negedge MCLK);
    check(AUTO_SAVE_EN, 1);
    fork
      begin
        repeat (4) @(negedge MCLK);
        POWER_FAIL = 1'b1;
      end
      busy_len(SAVE_LEN, ERS_LEN);
    join
    POWER_FAIL = 1'b0;
    wst(8'h00);
    done("power fail");
    wr(32'h5FFF, 1);
    fork
      cmd(OP_RESTORE);
      busy_len(RCL_LEN, 0);
    join
    fork
      pull();
      no_busy(20);
    join
    rd(32'h5FFF, 1, 0, -1, 0);
    done("restore");
    end_of_test();
  end
endmodule // spi_nv_sram_store_control_test

// ==== verilog/snvc_core.sv ====
// snvc_core: spi slave sram core with nonvolatile save/restore control
// assumes: SCK, SI, CS_N, HOLD_N come from one spi master in mode 0 or 3;
// SCK only runs inside frames; MCLK runs free; RST_N acts as power-up
// Contract
// [RQ1] array of 32768 bytes in one linear address space
// [RQ2] spi slave only, modes (0,0) and (1,1); master uses one
// [RQ3] selected only while chip select active; SI, SO, SCK carry data
// [RQ4] write is opcode, two address bytes, data bytes, no wait
// [RQ5] burst write steps address, wraps top to 0x0000
// [RQ6] read is opcode plus two address bytes, data at once
// [RQ7] fast read adds one dummy byte before data
// [RQ8] burst read steps address, wraps top to 0x0000
// [RQ9] pause input freezes transfer without losing progress
// [RQ10] protect pin, write-disable command, quarter/half/all block guard
// [RQ11] decode save, restore, auto save off, auto save on
// [RQ12] save triggered by power fail, save command or request pin
// [RQ13] save erases nonvolatile cells then programs them
// [RQ14] no memory access while save or restore runs
// [RQ15] busy pin low and status busy flag 1 while busy
// [RQ16] power-fail and pin saves skipped unless dirty since last save
// [RQ17] save command always performed
// [RQ18] power loss blocks access at once and starts conditional save
// [RQ19] host disables auto save when no backup capacitor fitted
// [RQ20] host rewrites status after a corrupted save
// [RQ21] SI sampled on rising SCK, SO changed on falling SCK
// [RQ22] first byte of a frame is the opcode, one per frame
// [RQ23] deselect idles the port and SI is ignored
// [RQ24] address msb first, only low 15 bits used
// [RQ25] protected write discarded, dirty flag untouched
`timescale 1ns/10ps
module snvc_core
  import snvc_pkg::*;
(
  // system
  input wire logic MCLK,
  input wire logic RST_N,
  // spi link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  output logic SO,
  output logic SO_OE,
  // pins
  input wire logic WP_N,
  input wire logic POWER_FAIL,
  input wire logic SAVE_BUSY_REQUEST_PIN_IN,
  output logic SAVE_BUSY_REQUEST_PIN_OUT,
  output logic SAVE_BUSY_REQUEST_PIN_OE,
  // state
  output snvc_phase_t NV_PHASE,
  output logic AUTO_SAVE_EN
);

  // ---- link domain (SCK) ----
  logic [7:0] mem [MEM_DEPTH]; // see [RQ1]
  snvc_spi_st_t st_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [2:0] bit_cnt_q;
  logic adr_byte_q;
  logic [ADDR_W-1:0] addr_q;
  logic wel_q;
  logic [1:0] guard_q;
  logic pin_en_q;
  snvc_ev_t ev_tgl_q;
  logic blk_s1_q, blk_s2_q;
  logic wp_s1_q, wp_s2_q;
  logic so_q;
  logic run;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] out_byte;
  logic [7:0] stat_byte;
  logic prot;
  logic mem_we;
  logic blk_q;

  // modes 0 and 3 both sample on the rising edge, so no mode logic
  assign run = !CS_N && HOLD_N; // see [RQ9] [RQ23] [RQ2]
  assign rx_byte = {sh_q[6:0], SI};
  assign byte_done = run && (bit_cnt_q == 3'h7);

  always_comb begin
    prot = 1'b0;
    case (guard_q) // see [RQ10]
      2'h1: prot = addr_q >= QUARTER_BASE;
      2'h2: prot = addr_q >= HALF_BASE;
      2'h3: prot = 1'b1;
      default: prot = 1'b0;
    endcase
    if (!wel_q || (pin_en_q && !wp_s2_q)) begin
      prot = 1'b1;
    end
  end

  // see [RQ25] [RQ14] [RQ4]
  assign mem_we = byte_done && (st_q == SP_WR) && !prot && !blk_s2_q;

  // frame state; deselect puts it back to opcode wait
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      st_q <= SP_OPC; // see [RQ22] [RQ23]
      sh_q <= 8'h00;
      op_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      adr_byte_q <= 1'b0;
      addr_q <= '0;
    end else if (HOLD_N) begin
      sh_q <= rx_byte; // see [RQ21]
      bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
      if (st_q == SP_ADDR) begin
        addr_q <= {addr_q[ADDR_W-2:0], SI}; // see [RQ24]
      end
      if (byte_done) begin
        case (st_q)
          SP_OPC: begin
            op_q <= rx_byte;
            case (rx_byte)
              OP_READ, OP_FREAD, OP_WRITE: st_q <= SP_ADDR;
              OP_RDSTAT: st_q <= SP_SRD;
              OP_WRSTAT: st_q <= SP_SWR;
              default: st_q <= SP_IGN;
            endcase
          end
          SP_ADDR: begin
            adr_byte_q <= 1'b1;
            if (adr_byte_q) begin
              case (op_q)
                OP_WRITE: st_q <= SP_WR; // see [RQ4]
                OP_FREAD: st_q <= SP_DUMMY; // see [RQ7]
                default: st_q <= SP_RD; // see [RQ6]
              endcase
            end
          end
          SP_DUMMY: st_q <= SP_RD;
          SP_WR, SP_RD: addr_q <= ADDR_W'(addr_q + 1'b1); // see [RQ5] [RQ8]
          SP_SWR: st_q <= SP_IGN;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  always_ff @(posedge SCK) begin
    if (mem_we) begin
      mem[addr_q] <= rx_byte;
    end
  end

  // protection state lives across frames
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      wel_q <= 1'b0;
      guard_q <= GUARD_RST;
      pin_en_q <= 1'b0;
    end else if (byte_done && st_q == SP_OPC && rx_byte == OP_WREN) begin
      wel_q <= 1'b1;
    end else if (byte_done && st_q == SP_OPC && rx_byte == OP_WRDIS) begin
      wel_q <= 1'b0; // see [RQ10]
    end else if (byte_done && st_q == SP_SWR && wel_q && !(pin_en_q && !wp_s2_q)) begin
      guard_q <= {rx_byte[ST_GUARD_HI], rx_byte[ST_GUARD_LO]};
      pin_en_q <= rx_byte[ST_PIN_EN];
    end
  end

  // events leave this domain as toggles
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      ev_tgl_q <= '0;
    end else begin
      if (mem_we) begin
        ev_tgl_q.wr <= !ev_tgl_q.wr;
      end
      if (byte_done && st_q == SP_OPC && !blk_s2_q) begin
        case (rx_byte) // see [RQ11]
          OP_SAVE: ev_tgl_q.save <= !ev_tgl_q.save;
          OP_RESTORE: ev_tgl_q.rcl <= !ev_tgl_q.rcl;
          OP_ASOFF: ev_tgl_q.as_off <= !ev_tgl_q.as_off;
          OP_ASON: ev_tgl_q.as_on <= !ev_tgl_q.as_on;
          default: ev_tgl_q.wr <= ev_tgl_q.wr;
        endcase
      end
    end
  end

  // busy level and protect pin, two flops each
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      blk_s1_q <= 1'b1;
      blk_s2_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else begin
      blk_s1_q <= blk_q;
      blk_s2_q <= blk_s1_q;
      wp_s1_q <= WP_N;
      wp_s2_q <= wp_s1_q;
    end
  end

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[ST_BUSY] = blk_s2_q; // see [RQ15]
    stat_byte[ST_WEL] = wel_q;
    stat_byte[ST_GUARD_LO] = guard_q[0];
    stat_byte[ST_GUARD_HI] = guard_q[1];
    stat_byte[ST_PIN_EN] = pin_en_q;
  end

  // reads while busy return all ones instead of array data
  assign out_byte = (st_q == SP_SRD) ? stat_byte : (blk_s2_q ? 8'hFF : mem[addr_q]);

  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      so_q <= 1'b0;
    end else if (HOLD_N) begin
      so_q <= out_byte[3'(~bit_cnt_q)]; // see [RQ21]
    end
  end

  assign SO = so_q;
  assign SO_OE = run && (st_q == SP_RD || st_q == SP_SRD); // see [RQ3]

  // ---- system domain (MCLK) ----
  snvc_ev_t ev_s1_q, ev_s2_q, ev_s3_q;
  snvc_ev_t ev;
  logic pf_s1_q, pf_s2_q;
  logic hreq_s1_q, hreq_s2_q;
  logic auto_en_q;
  logic dirty_q;
  snvc_nv_st_t nv_q;
  logic [15:0] cnt_q;
  logic start_save;
  logic start_rcl;
  logic idle;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
      pf_s1_q <= 1'b0;
      pf_s2_q <= 1'b0;
      hreq_s1_q <= 1'b1;
      hreq_s2_q <= 1'b1;
    end else begin
      ev_s1_q <= ev_tgl_q;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      pf_s1_q <= POWER_FAIL;
      pf_s2_q <= pf_s1_q;
      hreq_s1_q <= SAVE_BUSY_REQUEST_PIN_IN;
      hreq_s2_q <= hreq_s1_q;
    end
  end

  assign ev = ev_s2_q ^ ev_s3_q;
  assign idle = nv_q == NV_IDLE;
  // command save ignores dirty; pin and power-fail saves need it
  assign start_save = idle && (ev.save // see [RQ17] [RQ12]
    || (pf_s2_q && auto_en_q && dirty_q) // see [RQ18] [RQ16]
    || (!hreq_s2_q && dirty_q)); // see [RQ16]
  assign start_rcl = idle && ev.rcl && !start_save;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      auto_en_q <= AUTO_SAVE_RST;
    end else if (ev.as_off) begin
      auto_en_q <= 1'b0; // see [RQ11]
    end else if (ev.as_on) begin
      auto_en_q <= 1'b1;
    end
  end

  // a write in the same cycle as the clear keeps the flag set
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      dirty_q <= 1'b0;
    end else if (ev.wr) begin
      dirty_q <= 1'b1;
    end else if (start_save || start_rcl) begin
      dirty_q <= 1'b0; // see [RQ16]
    end
  end

  // reset performs the power-up restore first
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      nv_q <= NV_RCL_CLR;
      cnt_q <= RCL_CLR_CYC;
    end else begin
      cnt_q <= 16'(cnt_q - 16'h0001);
      case (nv_q)
        NV_IDLE: begin
          if (start_save) begin
            nv_q <= NV_ERASE;
            cnt_q <= ERASE_CYC;
          end else if (start_rcl) begin
            nv_q <= NV_RCL_CLR;
            cnt_q <= RCL_CLR_CYC;
          end else begin
            cnt_q <= cnt_q;
          end
        end
        NV_ERASE: if (cnt_q == 16'h0000) begin
          nv_q <= NV_PROG; // see [RQ13]
          cnt_q <= PROG_CYC;
        end
        NV_RCL_CLR: if (cnt_q == 16'h0000) begin
          nv_q <= NV_RCL_LOAD;
          cnt_q <= RCL_LOAD_CYC;
        end
        NV_PROG, NV_RCL_LOAD: if (cnt_q == 16'h0000) begin
          nv_q <= NV_IDLE;
        end
        default: nv_q <= NV_IDLE;
      endcase
    end
  end

  // power loss and a held request pin block access before any save
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      blk_q <= 1'b1;
    end else begin
      blk_q <= !idle || start_save || start_rcl || pf_s2_q || !hreq_s2_q; // see [RQ14] [RQ18]
    end
  end

  assign SAVE_BUSY_REQUEST_PIN_OUT = 1'b0;
  assign SAVE_BUSY_REQUEST_PIN_OE = !idle; // see [RQ15]
  assign NV_PHASE = {nv_q == NV_ERASE, nv_q == NV_PROG,
    nv_q == NV_RCL_CLR || nv_q == NV_RCL_LOAD};
  assign AUTO_SAVE_EN = auto_en_q;

  // ---- checks ----
  a_busy_pin_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    SAVE_BUSY_REQUEST_PIN_OE == (NV_PHASE != 3'h0) && !SAVE_BUSY_REQUEST_PIN_OUT)
    else $error("busy pin not driven low"); // see [RQ15]
  a_erase_first: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(nv_q == NV_PROG) |-> $past(nv_q) == NV_ERASE) else $error("program without erase"); // see [RQ13]
  a_cmd_save_runs: assert property (@(posedge MCLK) disable iff (!RST_N)
    idle && ev.save |=> nv_q == NV_ERASE) else $error("command save skipped"); // see [RQ17]
  a_clean_pf_skip: assert property (@(posedge MCLK) disable iff (!RST_N)
    idle && !dirty_q && !ev.save && !ev.rcl |=> idle) else $error("clean save ran"); // see [RQ16]
  a_pf_blocks: assert property (@(posedge MCLK) disable iff (!RST_N)
    pf_s2_q |=> blk_q) else $error("power loss did not block"); // see [RQ18]
  a_dirty_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
    ev.wr |=> dirty_q ##1 1'b1) else $error("write not marked dirty"); // see [RQ16]
  a_no_guarded_wr: assert property (@(posedge SCK) disable iff (CS_N)
    mem_we |-> !prot && wel_q) else $error("guarded write stored"); // see [RQ25]
  a_no_busy_wr: assert property (@(posedge SCK) disable iff (CS_N)
    mem_we |-> !blk_s2_q) else $error("write while busy"); // see [RQ14]
  a_addr_wraps: assert property (@(posedge SCK) disable iff (CS_N)
    byte_done && st_q == SP_WR && addr_q == TOP_ADDR |=> addr_q == '0)
    else $error("burst did not wrap"); // see [RQ5]
  a_hold_freeze: assert property (@(posedge SCK) disable iff (CS_N)
    !HOLD_N |=> $stable(bit_cnt_q) && $stable(addr_q)) else $error("pause lost state"); // see [RQ9]

  c_cmd_save: cover property (@(posedge MCLK) disable iff (!RST_N) idle && ev.save);
  c_pin_save: cover property (@(posedge MCLK) disable iff (!RST_N) idle && !hreq_s2_q && dirty_q);
  c_pf_save: cover property (@(posedge MCLK) disable iff (!RST_N) idle && pf_s2_q && dirty_q);
  c_read_wrap: cover property (@(posedge SCK) disable iff (CS_N)
    byte_done && st_q == SP_RD && addr_q == TOP_ADDR);

endmodule // snvc_core
